// [inc/fcs_pkg.sv]
// Constants, register map and encodings for the Fibre Channel stimulus and status block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
package fcs_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_BURST   = 8'h04;
   localparam logic [7:0] OFS_TXDEV   = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;
   localparam logic [7:0] OFS_TRAP    = 8'h10;
   localparam logic [7:0] OFS_DEVPPM  = 8'h14;
   localparam logic [7:0] OFS_DEVBPS  = 8'h18;
   localparam logic [7:0] OFS_ACCUM   = 8'h1C;
   localparam logic [7:0] OFS_PATERR  = 8'h20;
   localparam logic [7:0] OFS_CMD     = 8'h24;
   localparam logic [7:0] OFS_NOMINAL = 8'h28;
   localparam logic [7:0] OFS_PPMMULT = 8'h2C;
   localparam logic [7:0] OFS_FRBITS  = 8'h30;

   // Control register field positions.
   localparam int CTRL_ALARM_LSB = 0;
   localparam int CTRL_ERR_LSB   = 4;
   localparam int CTRL_MODE_LSB  = 8;
   localparam int CTRL_PORT_LSB  = 12;
   localparam int CTRL_CRC_BIT   = 16;
   localparam int CTRL_LOST_BIT  = 17;

   // Command register bits, write one to act.
   localparam int CMD_TRIG_BIT  = 0;
   localparam int CMD_START_BIT = 1;

   // Reset values.
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [15:0] BURST_RST   = 16'h0001;
   localparam logic [31:0] NOMINAL_RST = 32'h0000_0000;
   localparam logic [31:0] PPMMULT_RST = 32'h0000_0000;
   localparam logic [15:0] FRBITS_RST  = 16'h0000;

   // Scale shift for the parts-per-million product.
   localparam int PPM_SHIFT = 24;

   // Characters, first byte sent first in bits 7:0.
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [7:0] D9_2  = 8'h49;
   localparam logic [7:0] D31_5 = 8'hBF;
   localparam logic [7:0] D21_1 = 8'h35;
   localparam logic [7:0] D21_2 = 8'h55;
   localparam logic [7:0] D5_2  = 8'h45;
   localparam logic [7:0] D10_4 = 8'h8A;
   localparam logic [7:0] D21_4 = 8'h95;
   localparam logic [7:0] D10_2 = 8'h4A;
   localparam logic [9:0] BAD_CODE_10B = 10'h000;

   typedef enum logic [2:0] {
      ALM_NONE = 3'b000, ALM_LR = 3'b001, ALM_LRR = 3'b010, ALM_NOS = 3'b011, ALM_OLS = 3'b100
   } fcs_alarm_t;

   typedef enum logic [2:0] {
      ERR_NONE = 3'b000, ERR_BIT = 3'b001, ERR_SYM = 3'b010,
      ERR_RRDY = 3'b011, ERR_CRC = 3'b100, ERR_BLOCK = 3'b101
   } fcs_err_t;

   // Insertion modes: 4 to 9 are the rates 1E-02 to 1E-07.
   localparam logic [3:0] INS_OFF    = 4'h0;
   localparam logic [3:0] INS_MANUAL = 4'h1;
   localparam logic [3:0] INS_SEC    = 4'h2;
   localparam logic [3:0] INS_10SEC  = 4'h3;
   localparam logic [3:0] INS_RATE2  = 4'h4;
   localparam logic [3:0] INS_RATE7  = 4'h9;

   // Port modes: 1 to 4 use 8b/10b, 5 and 6 use 64b/66b.
   localparam logic [2:0] PORT_OFF    = 3'h0;
   localparam logic [2:0] PORT_FC1200 = 3'h5;
   localparam logic [2:0] PORT_FC1600 = 3'h6;

   // Word region codes from the frame generator.
   localparam logic [1:0] REG_IDLE    = 2'h0;
   localparam logic [1:0] REG_PAYLOAD = 2'h1;
   localparam logic [1:0] REG_CRC     = 2'h2;
   localparam logic [1:0] REG_DELIM   = 2'h3;

   // Timing.
   localparam longint CLK_HZ        = 25000000;
   localparam longint PERIOD_S      = 1;
   localparam longint PERIOD_CYCLES = CLK_HZ * PERIOD_S;
   localparam logic [3:0] TEN_PERIODS = 4'hA;

endpackage : fcs_pkg

// [logic/fcs_stim.sv]
// Fibre Channel transmit stimulus injector and receive status block.
// Sits between the frame generator and the line encoder; receive inputs come from the decoder.
`timescale 1ns/1ps
// What this block does
// [R1] A selected alarm replaces traffic with its primitive sequence continuously until none.
// [R2] Link reset sends K28.5 D9.2 D31.5 D9.2.
// [R3] Link reset response sends K28.5 D21.1 D31.5 D9.2.
// [R4] Not operational sends K28.5 D21.2 D31.5 D5.2.
// [R5] Offline sends K28.5 D21.1 D10.4 D21.2.
// [R6] Receiver ready error sends one K28.5 D21.4 D10.2 D10.2 per event.
// [R7] Bit error inverts one payload bit per event, delimiters untouched.
// [R8] Symbol error sends one undecodable 10-bit group; not at 64b/66b rates.
// [R9] CRC error flips one check field bit; not without a check field.
// [R10] Block error corrupts one 64b/66b block; only at the two top rates.
// [R11] Manual mode inserts exactly burst length errors per trigger.
// [R12] Periodic modes insert one burst every second or every ten seconds.
// [R13] Rate modes insert one burst per ten-to-the-n transmitted blocks.
// [R14] Insertion off stops all insertion and ignores triggers.
// [R15] Signed deviation offsets transmit rate; positive raises frequency.
// [R16] Received rate deviation is reported in ppm and bits per second.
// [R17] Accumulated bit difference is kept and cleared on measurement start.
// [R18] Signal present follows bit synchronisation.
// [R19] Sync flag shows word alignment acquired or lost.
// [R20] Every alarm or error seen is latched in a trap until cleared.
// [R21] With lost-frame option, lost frame pattern bits add to pattern errors.
// [R22] Lower four rates use 8b/10b, two highest use 64b/66b.
module fcs_stim #(
   parameter longint PERIOD_CYCLES = fcs_pkg::PERIOD_CYCLES,
   parameter longint GATE_CYCLES   = 2500000,
   parameter longint GATES_PER_SEC = 10
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Transmit stream from the frame generator.
   input  wire logic        tx_in_valid,
   input  wire logic [31:0] tx_in_data,
   input  wire logic [3:0]  tx_in_k,
   input  wire logic [1:0]  tx_in_region,
   input  wire logic        tx_in_blk,
   // Transmit stream to the encoder.
   output logic             tx_out_valid,
   output logic      [31:0] tx_out_data,
   output logic      [3:0]  tx_out_k,
   output logic             tx_out_sym_sel,
   output logic      [9:0]  tx_out_sym,
   output logic             tx_out_blk_err,
   output logic             tx_use_66b,
   output logic signed [15:0] tx_rate_trim,
   // Receive status.
   input  wire logic        rx_sig_det,
   input  wire logic        rx_word_lock,
   input  wire logic [9:0]  rx_bit_inc,
   input  wire logic [7:0]  rx_pat_err_inc,
   input  wire logic        rx_frame_lost
);

   logic [31:0] ctrl_reg;
   logic [15:0] burst_reg;
   logic [15:0] txdev_reg;
   logic [31:0] nominal_reg;
   logic [31:0] ppmmult_reg;
   logic [15:0] frbits_reg;
   logic [3:0]  trap_reg;
   logic        trig_reg;
   logic        start_reg;
   logic [16:0] pend_reg;
   logic [24:0] per_cnt_reg;
   logic [3:0]  ten_cnt_reg;
   logic [23:0] blk_cnt_reg;
   logic [2:0]  sig_sync_reg;
   logic [2:0]  lock_sync_reg;
   logic        sig_reg;
   logic        lock_reg;
   logic [23:0] gate_cnt_reg;
   logic [31:0] bits_cnt_reg;
   logic signed [31:0] diff_reg;
   logic signed [31:0] ppm_reg;
   logic signed [31:0] bps_reg;
   logic signed [31:0] accum_reg;
   logic        gate_done_reg;
   logic [31:0] paterr_reg;

   fcs_pkg::fcs_alarm_t alarm_sel;
   fcs_pkg::fcs_err_t   err_sel;
   logic [3:0]  ins_mode;
   logic [2:0]  port_mode;
   logic        wb_req;
   logic        wb_wr;
   logic        burst_evt;
   logic        type_ok;
   logic        eligible;
   logic        do_ins;
   logic [31:0] oset;
   logic [3:0]  trap_set;
   logic [3:0]  trap_clr;

   // Merges write data into a register under the byte selects.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   // Blocks per burst for rate modes 4 to 9.
   function automatic logic [23:0] rate_blocks(input logic [3:0] mode);
      logic [23:0] n;
      n = 24'h000064;
      for (int i = 4; i < 9; i++) begin
         if (mode > 4'(i)) begin
            n = 24'(n * 24'h00000A);
         end
      end
      return n;
   endfunction : rate_blocks

   assign alarm_sel = fcs_pkg::fcs_alarm_t'(ctrl_reg[fcs_pkg::CTRL_ALARM_LSB +: 3]);
   assign err_sel   = fcs_pkg::fcs_err_t'(ctrl_reg[fcs_pkg::CTRL_ERR_LSB +: 3]);
   assign ins_mode  = ctrl_reg[fcs_pkg::CTRL_MODE_LSB +: 4];
   assign port_mode = ctrl_reg[fcs_pkg::CTRL_PORT_LSB +: 3];
   assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr     = wb_req && wb_we_i;

   // Bus answer one cycle after the request, dropped the cycle after.
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Read data; unmapped addresses read zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            fcs_pkg::OFS_CTRL:    wb_dat_o <= ctrl_reg;
            fcs_pkg::OFS_BURST:   wb_dat_o <= {16'h0000, burst_reg};
            fcs_pkg::OFS_TXDEV:   wb_dat_o <= {16'h0000, txdev_reg};
            fcs_pkg::OFS_STATUS:  wb_dat_o <= {27'h0000000, pend_reg != 17'h00000,
                                               alarm_sel != fcs_pkg::ALM_NONE,
                                               tx_use_66b, lock_reg, sig_reg};
            fcs_pkg::OFS_TRAP:    wb_dat_o <= {28'h0000000, trap_reg};
            fcs_pkg::OFS_DEVPPM:  wb_dat_o <= ppm_reg;
            fcs_pkg::OFS_DEVBPS:  wb_dat_o <= bps_reg;
            fcs_pkg::OFS_ACCUM:   wb_dat_o <= accum_reg;
            fcs_pkg::OFS_PATERR:  wb_dat_o <= paterr_reg;
            fcs_pkg::OFS_NOMINAL: wb_dat_o <= nominal_reg;
            fcs_pkg::OFS_PPMMULT: wb_dat_o <= ppmmult_reg;
            fcs_pkg::OFS_FRBITS:  wb_dat_o <= {16'h0000, frbits_reg};
            default:              wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Software-written configuration.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg    <= fcs_pkg::CTRL_RST;
         burst_reg   <= fcs_pkg::BURST_RST;
         txdev_reg   <= 16'h0000;
         nominal_reg <= fcs_pkg::NOMINAL_RST;
         ppmmult_reg <= fcs_pkg::PPMMULT_RST;
         frbits_reg  <= fcs_pkg::FRBITS_RST;
      end else if (wb_wr) begin
         if (wb_adr_i == fcs_pkg::OFS_CTRL) begin
            ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0003_7F77;
         end
         if (wb_adr_i == fcs_pkg::OFS_BURST) begin
            burst_reg <= 16'(merge({16'h0000, burst_reg}, wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == fcs_pkg::OFS_TXDEV) begin
            txdev_reg <= 16'(merge({16'h0000, txdev_reg}, wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == fcs_pkg::OFS_NOMINAL) begin
            nominal_reg <= merge(nominal_reg, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == fcs_pkg::OFS_PPMMULT) begin
            ppmmult_reg <= merge(ppmmult_reg, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == fcs_pkg::OFS_FRBITS) begin
            frbits_reg <= 16'(merge({16'h0000, frbits_reg}, wb_dat_i, wb_sel_i));
         end
      end
   end

   // Command pulses, one cycle wide.
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_reg  <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         trig_reg  <= wb_wr && wb_adr_i == fcs_pkg::OFS_CMD && wb_sel_i[0]
                      && wb_dat_i[fcs_pkg::CMD_TRIG_BIT];
         start_reg <= wb_wr && wb_adr_i == fcs_pkg::OFS_CMD && wb_sel_i[0]
                      && wb_dat_i[fcs_pkg::CMD_START_BIT];
      end
   end

   // Coding follows the port mode; rate trim follows the transmit deviation register.
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_use_66b   <= 1'b0;
         tx_rate_trim <= 16'sh0000;
      end else begin
         tx_use_66b   <= port_mode == fcs_pkg::PORT_FC1200
                         || port_mode == fcs_pkg::PORT_FC1600; // [R22]
         tx_rate_trim <= signed'(txdev_reg); // [R15]
      end
   end

   // Period timers for the one and ten second modes.
   always_ff @(posedge clk) begin
      if (rst || ins_mode == fcs_pkg::INS_OFF) begin
         per_cnt_reg <= 25'h0000000;
         ten_cnt_reg <= 4'h0;
      end else if (per_cnt_reg == 25'(PERIOD_CYCLES - 1)) begin
         per_cnt_reg <= 25'h0000000;
         ten_cnt_reg <= (ten_cnt_reg == fcs_pkg::TEN_PERIODS - 4'h1) ? 4'h0 : ten_cnt_reg + 4'h1;
      end else begin
         per_cnt_reg <= per_cnt_reg + 25'h0000001;
      end
   end

   // Transmitted block counter for the rate modes.
   always_ff @(posedge clk) begin
      if (rst || ins_mode < fcs_pkg::INS_RATE2) begin
         blk_cnt_reg <= 24'h000000;
      end else if (tx_in_valid && tx_in_blk) begin
         blk_cnt_reg <= (blk_cnt_reg == rate_blocks(ins_mode) - 24'h000001) ? 24'h000000
                        : blk_cnt_reg + 24'h000001;
      end
   end

   always_comb begin
      burst_evt = 1'b0;
      unique case (1'b1)
         ins_mode == fcs_pkg::INS_MANUAL: burst_evt = trig_reg; // [R11]
         ins_mode == fcs_pkg::INS_SEC:
            burst_evt = per_cnt_reg == 25'(PERIOD_CYCLES - 1); // [R12]
         ins_mode == fcs_pkg::INS_10SEC:
            burst_evt = per_cnt_reg == 25'(PERIOD_CYCLES - 1)
                        && ten_cnt_reg == fcs_pkg::TEN_PERIODS - 4'h1; // [R12]
         ins_mode >= fcs_pkg::INS_RATE2 && ins_mode <= fcs_pkg::INS_RATE7:
            burst_evt = tx_in_valid && tx_in_blk
                        && blk_cnt_reg == rate_blocks(ins_mode) - 24'h000001; // [R13]
         default: burst_evt = 1'b0;
      endcase
   end

   // Error type availability and word eligibility.
   always_comb begin
      type_ok  = 1'b0;
      eligible = 1'b0;
      unique case (err_sel)
         fcs_pkg::ERR_BIT: begin
            type_ok  = 1'b1;
            eligible = tx_in_region == fcs_pkg::REG_PAYLOAD; // [R7]
         end
         fcs_pkg::ERR_SYM: begin
            type_ok  = !tx_use_66b; // [R8]
            eligible = tx_in_region == fcs_pkg::REG_IDLE;
         end
         fcs_pkg::ERR_RRDY: begin
            type_ok  = 1'b1;
            eligible = tx_in_region == fcs_pkg::REG_IDLE;
         end
         fcs_pkg::ERR_CRC: begin
            type_ok  = ctrl_reg[fcs_pkg::CTRL_CRC_BIT]; // [R9]
            eligible = tx_in_region == fcs_pkg::REG_CRC;
         end
         fcs_pkg::ERR_BLOCK: begin
            type_ok  = tx_use_66b; // [R10]
            eligible = tx_in_blk;
         end
         default: begin
            type_ok  = 1'b0;
            eligible = 1'b0;
         end
      endcase
   end

   assign do_ins = tx_in_valid && pend_reg != 17'h00000 && type_ok && eligible
                   && alarm_sel == fcs_pkg::ALM_NONE;

   // Pending error count; an event arriving during insertion is added, not lost.
   always_ff @(posedge clk) begin
      if (rst || ins_mode == fcs_pkg::INS_OFF || !type_ok) begin
         pend_reg <= 17'h00000; // [R14]
      end else begin
         pend_reg <= pend_reg - {16'h0000, do_ins}
                     + (burst_evt ? {1'b0, burst_reg} : 17'h00000); // [R11]
      end
   end

   always_comb begin
      unique case (alarm_sel)
         fcs_pkg::ALM_LR:  oset = {fcs_pkg::D9_2,  fcs_pkg::D31_5, fcs_pkg::D9_2,  fcs_pkg::K28_5}; // [R2]
         fcs_pkg::ALM_LRR: oset = {fcs_pkg::D9_2,  fcs_pkg::D31_5, fcs_pkg::D21_1, fcs_pkg::K28_5}; // [R3]
         fcs_pkg::ALM_NOS: oset = {fcs_pkg::D5_2,  fcs_pkg::D31_5, fcs_pkg::D21_2, fcs_pkg::K28_5}; // [R4]
         fcs_pkg::ALM_OLS: oset = {fcs_pkg::D21_2, fcs_pkg::D10_4, fcs_pkg::D21_1, fcs_pkg::K28_5}; // [R5]
         default:          oset = {fcs_pkg::D10_2, fcs_pkg::D10_2, fcs_pkg::D21_4, fcs_pkg::K28_5}; // [R6]
      endcase
   end

   // Output word: alarm replaces traffic, otherwise one error per insertion.
   always_ff @(posedge clk) begin
      if (rst || port_mode == fcs_pkg::PORT_OFF) begin
         tx_out_valid   <= 1'b0;
         tx_out_data    <= 32'h0000_0000;
         tx_out_k       <= 4'h0;
         tx_out_sym_sel <= 1'b0;
         tx_out_sym     <= fcs_pkg::BAD_CODE_10B;
         tx_out_blk_err <= 1'b0;
      end else begin
         tx_out_valid   <= tx_in_valid;
         tx_out_data    <= tx_in_data;
         tx_out_k       <= tx_in_k;
         tx_out_sym_sel <= 1'b0;
         tx_out_blk_err <= 1'b0;
         if (tx_in_valid && alarm_sel != fcs_pkg::ALM_NONE) begin
            tx_out_data <= oset; // [R1]
            tx_out_k    <= 4'h1; // [R1]
         end else if (do_ins) begin
            unique case (err_sel)
               fcs_pkg::ERR_BIT, fcs_pkg::ERR_CRC: begin
                  tx_out_data <= tx_in_data ^ 32'h0000_0001; // [R7] [R9]
               end
               fcs_pkg::ERR_SYM: tx_out_sym_sel <= 1'b1; // [R8]
               fcs_pkg::ERR_RRDY: begin
                  tx_out_data <= oset; // [R6]
                  tx_out_k    <= 4'h1;
               end
               fcs_pkg::ERR_BLOCK: tx_out_blk_err <= 1'b1; // [R10]
               default: tx_out_data <= tx_in_data;
            endcase
         end
      end
   end

   // Pin inputs pass three flops; a change counts once the last two agree.
   always_ff @(posedge clk) begin
      if (rst) begin
         sig_sync_reg  <= 3'h0;
         lock_sync_reg <= 3'h0;
         sig_reg       <= 1'b0;
         lock_reg      <= 1'b0;
      end else begin
         sig_sync_reg  <= {sig_sync_reg[1:0], rx_sig_det};
         lock_sync_reg <= {lock_sync_reg[1:0], rx_word_lock};
         if (sig_sync_reg[2] == sig_sync_reg[1]) begin
            sig_reg <= sig_sync_reg[2]; // [R18]
         end
         if (lock_sync_reg[2] == lock_sync_reg[1]) begin
            lock_reg <= lock_sync_reg[2] && sig_reg; // [R19]
         end
      end
   end

   // Rate measurement over a fixed gate.
   always_ff @(posedge clk) begin
      if (rst || start_reg) begin
         gate_cnt_reg  <= 24'h000000;
         bits_cnt_reg  <= 32'h0000_0000;
         gate_done_reg <= 1'b0;
         diff_reg      <= 32'sh0000_0000;
      end else if (gate_cnt_reg == 24'(GATE_CYCLES - 1)) begin
         gate_cnt_reg  <= 24'h000000;
         bits_cnt_reg  <= {22'h000000, rx_bit_inc};
         gate_done_reg <= 1'b1;
         diff_reg      <= signed'(bits_cnt_reg - nominal_reg);
      end else begin
         gate_cnt_reg  <= gate_cnt_reg + 24'h000001;
         bits_cnt_reg  <= bits_cnt_reg + {22'h000000, rx_bit_inc};
         gate_done_reg <= 1'b0;
      end
   end

   // Deviation results, one cycle after each gate closes.
   always_ff @(posedge clk) begin
      if (rst || start_reg) begin
         ppm_reg   <= 32'sh0000_0000;
         bps_reg   <= 32'sh0000_0000;
         accum_reg <= 32'sh0000_0000; // [R17]
      end else if (gate_done_reg) begin
         ppm_reg   <= 32'((64'(diff_reg) * signed'({32'h0000_0000, ppmmult_reg}))
                          >>> fcs_pkg::PPM_SHIFT); // [R16]
         bps_reg   <= 32'(diff_reg * 32'(GATES_PER_SEC)); // [R16]
         accum_reg <= accum_reg + diff_reg; // [R17]
      end
   end

   // Pattern error counter.
   always_ff @(posedge clk) begin
      if (rst || start_reg) begin
         paterr_reg <= 32'h0000_0000;
      end else begin
         paterr_reg <= paterr_reg + {24'h000000, rx_pat_err_inc}
                       + ((rx_frame_lost && ctrl_reg[fcs_pkg::CTRL_LOST_BIT])
                          ? {16'h0000, frbits_reg} : 32'h0000_0000); // [R21]
      end
   end

   // Sticky trap; a new event in the clearing cycle survives.
   assign trap_set = {rx_frame_lost, rx_pat_err_inc != 8'h00, !lock_reg, !sig_reg};
   assign trap_clr = (wb_wr && wb_adr_i == fcs_pkg::OFS_TRAP && wb_sel_i[0])
                     ? wb_dat_i[3:0] : 4'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         trap_reg <= 4'h0;
      end else begin
         trap_reg <= (trap_reg & ~trap_clr) | trap_set; // [R20]
      end
   end

endmodule : fcs_stim

// [verification/fcs_stim_monitor.sv]
// Port checker for the stimulus and status block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module fcs_stim_monitor (
   // Clock, reset and bus handshake.
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // Transmit stream.
   input wire logic        tx_in_valid,
   input wire logic [31:0] tx_in_data,
   input wire logic [3:0]  tx_in_k,
   input wire logic [1:0]  tx_in_region,
   input wire logic        tx_in_blk,
   input wire logic        tx_out_valid,
   input wire logic [31:0] tx_out_data,
   input wire logic [3:0]  tx_out_k,
   input wire logic        tx_out_sym_sel,
   input wire logic [9:0]  tx_out_sym,
   input wire logic        tx_out_blk_err,
   input wire logic        tx_use_66b
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_ack_single:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   chk_ack_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   chk_out_follows:
      assert property (!$past(tx_in_valid) |-> !tx_out_valid) else $error("stray word");
   chk_payload_bits:
      assert property (tx_out_valid && tx_out_k == 4'h0 |->
         tx_out_data[31:1] == $past(tx_in_data[31:1])) else $error("extra bits changed");
   chk_delim_kept:
      assert property (tx_out_valid && tx_out_k == $past(tx_in_k)
         && $past(tx_in_region) == fcs_pkg::REG_DELIM |-> tx_out_data == $past(tx_in_data))
         else $error("delimiter changed");
   chk_sym_rate:
      assert property (tx_out_sym_sel |-> !tx_use_66b
         && tx_out_sym == fcs_pkg::BAD_CODE_10B) else $error("bad symbol insert");
   chk_block_rate:
      assert property (tx_out_blk_err |-> tx_use_66b && $past(tx_in_blk))
         else $error("bad block insert");
   chk_ordered_set:
      assert property (tx_out_valid && tx_out_k == 4'h1 && tx_out_data[7:0] == fcs_pkg::K28_5
         |-> tx_out_data[31:8] inside {24'h49BF49, 24'h49BF35, 24'h45BF55, 24'h558A35,
         24'h4A4A95}) else $error("unknown ordered set");
   cover property (tx_out_valid && tx_out_k == 4'h1);
   cover property (tx_out_sym_sel);
   cover property (tx_out_blk_err);
endmodule : fcs_stim_monitor
bind fcs_stim fcs_stim_monitor mon_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .tx_in_valid, .tx_in_data, .tx_in_k, .tx_in_region, .tx_in_blk, .tx_out_valid,
   .tx_out_data, .tx_out_k, .tx_out_sym_sel, .tx_out_sym, .tx_out_blk_err, .tx_use_66b);

// [verification/fcs_far_port.sv]
// Far-end port model feeding the receive status inputs.
// Assumes the bench steers signal presence and frame loss.
`timescale 1ns/1ps
module fcs_far_port (
   // Control from the bench.
   input wire logic  clk,
   input wire logic  sig_on,
   input wire logic  drop,
   // Receive status outputs.
   output logic       rx_sig_det,
   output logic       rx_word_lock,
   output logic [9:0] rx_bit_inc,
   output logic [7:0] rx_pat_err_inc,
   output logic       rx_frame_lost
);
   // The line clock is recovered, so bits arrive only with a signal.
   always_ff @(posedge clk) begin
      rx_sig_det     <= sig_on;
      rx_word_lock   <= sig_on;
      rx_bit_inc     <= sig_on ? 10'h00A : 10'h000;
      rx_pat_err_inc <= 8'h00;
      rx_frame_lost  <= drop;
   end
endmodule : fcs_far_port

// [verification/test_fcs_stim.sv]
// Self-checking bench for the stimulus and status block.
// Assumes short second and gate parameters to keep the run brief.
`timescale 1ns/1ps
module test_fcs_stim;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, vin = 0, sig_on = 0, drop = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, din = 32'h0, wdo, tdo, r;
   logic [1:0] rg = 2'h0;
   logic ack, tov, use66;
   logic [3:0] tk;
   logic signed [15:0] trim;
   logic sd, wl, fl, ss, be;
   logic [9:0] bi, sym;
   logic [7:0] pe;
   int fails = 0, checked = 0, hits, evs;
   fcs_stim #(.PERIOD_CYCLES(50), .GATE_CYCLES(20)) dut_u (.clk, .rst, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(wdo), .wb_ack_o(ack), .tx_in_valid(vin), .tx_in_data(din), .tx_in_k(4'h0),
      .tx_in_region(rg), .tx_in_blk(vin), .tx_out_valid(tov), .tx_out_data(tdo),
      .tx_out_k(tk), .tx_out_sym_sel(ss), .tx_out_sym(sym), .tx_out_blk_err(be),
      .tx_use_66b(use66),
      .tx_rate_trim(trim), .rx_sig_det(sd), .rx_word_lock(wl), .rx_bit_inc(bi),
      .rx_pat_err_inc(pe), .rx_frame_lost(fl));
   fcs_far_port far_u (.clk, .sig_on, .drop, .rx_sig_det(sd), .rx_word_lock(wl),
      .rx_bit_inc(bi), .rx_pat_err_inc(pe), .rx_frame_lost(fl));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic final_report;
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      r = wdo;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : bus
   task automatic run(input int n, input logic [1:0] reg_c, input logic [31:0] ed,
      input logic [31:0] ek);
      hits = 0;
      evs = 0;
      for (int i = 0; i < n + 3; i++) begin
         @(posedge clk);
         if (tov === 1'b1 && tdo === ed && {28'h0, tk} === ek) hits++;
         if ((ss === 1'b1 && sym === fcs_pkg::BAD_CODE_10B) || be === 1'b1) evs++;
         vin <= (i < n); rg <= reg_c; din <= 32'h0;
      end
   endtask : run
   initial begin
      #(40 * 20000);
      fails++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(0, 8'h04, 0); chk(r, 32'h1);
      bus(0, 8'h40, 0); chk(r, 32'h0);
      for (int a = 1; a < 5; a++) begin
         bus(1, 8'h00, 32'h1000 | a);
         run(3, 2'h0, a == 1 ? 32'h49BF49BC : a == 2 ? 32'h49BF35BC :
            a == 3 ? 32'h45BF55BC : 32'h558A35BC, 1);
         chk(hits, 3);
      end
      bus(1, 8'h04, 2); bus(1, 8'h00, 32'h1130); bus(1, 8'h24, 1);
      run(6, 2'h0, 32'h4A4A95BC, 1); chk(hits, 2);
      bus(1, 8'h00, 32'h1030); bus(1, 8'h24, 1);
      run(6, 2'h0, 32'h4A4A95BC, 1); chk(hits, 0);
      bus(1, 8'h04, 1); bus(1, 8'h00, 32'h1110); bus(1, 8'h24, 1);
      run(4, 2'h3, 32'h1, 0); chk(hits, 0);
      run(4, 2'h1, 32'h1, 0); chk(hits, 1);
      bus(1, 8'h00, 32'h11140); bus(1, 8'h24, 1);
      run(4, 2'h2, 32'h1, 0); chk(hits, 1);
      bus(1, 8'h00, 32'h1120); bus(1, 8'h24, 1);
      run(4, 2'h0, 32'h0, 0); chk(evs, 1);
      bus(1, 8'h00, 32'h6150); bus(1, 8'h24, 1);
      run(4, 2'h0, 32'h0, 0); chk(evs, 1);
      chk(use66, 1);
      bus(1, 8'h08, 32'hFFFB); @(posedge clk); chk({16'h0, trim}, 32'hFFFB);
      sig_on <= 1; repeat (10) @(posedge clk);
      bus(0, 8'h0C, 0); chk(r & 32'h3, 3);
      bus(1, 8'h10, 32'hF); bus(0, 8'h10, 0); chk(r & 32'h1, 0);
      sig_on <= 0; repeat (10) @(posedge clk);
      bus(0, 8'h0C, 0); chk(r & 32'h3, 0);
      bus(0, 8'h10, 0); chk(r & 32'h1, 1);
      bus(1, 8'h00, 32'h20000); bus(1, 8'h30, 100); bus(1, 8'h24, 2);
      drop <= 1; @(posedge clk); drop <= 0; repeat (6) @(posedge clk);
      bus(0, 8'h20, 0); chk(r, 100);
      bus(1, 8'h28, 5); bus(1, 8'h2C, 32'h0100_0000); bus(1, 8'h24, 2);
      bus(0, 8'h1C, 0); chk(r, 0);
      repeat (25) @(posedge clk);
      bus(0, 8'h1C, 0); chk(r, 32'hFFFFFFFB);
      bus(0, 8'h14, 0); chk(r, 32'hFFFFFFFB);
      bus(0, 8'h18, 0); chk(r, 32'hFFFFFFCE);
      bus(1, 8'h00, 32'h1230); run(120, 2'h0, 32'h4A4A95BC, 1); chk(hits, 2);
      bus(1, 8'h00, 32'h1430); run(150, 2'h0, 32'h4A4A95BC, 1); chk(hits, 1);
      final_report();
   end
endmodule : test_fcs_stim
